/* hsc_enable_limit.sv */
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "hsc_regs.svh"
module hsc_enable_limit import hsc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // enable pin comparators
  input wire logic en_above_upper,
  input wire logic en_below_lower,
  // measurements, volts in 1/32 V, current in 0.5 A
  input wire logic [11:0] vin_code,
  input wire logic [11:0] vout_code,
  input wire logic [11:0] vgs_code,
  input wire logic [8:0] isense_code,
  input wire logic [7:0] fet_temp,
  // fault sources
  input wire logic soc_trip,
  input wire logic [3:0] fault_evt,
  input wire logic mem_err,
  // gate drive
  output logic gate_en,
  output logic [7:0] gate_level
);
  hsc_soa_if sif();

  hsc_soa_table u_table (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sif(sif)
  );

  function automatic hsc_amp_t amp_min(input hsc_amp_t a, input hsc_amp_t b);
    amp_min = (a < b) ? a : b;
  endfunction

  function automatic logic is_active(input hsc_state_t s);
    is_active = (s == HSC_ST_INIT) || (s == HSC_ST_ON) ||
      (s == HSC_ST_IREG) || (s == HSC_ST_UVOFF);
  endfunction

  hsc_state_t state_reg, state_next;
  logic [10:0] ctrl_reg;
  logic [6:0] fault_reg, fault_next;
  hsc_amp_t oc_reg, ist_reg;
  logic [8:0] saddr_reg;
  logic [9:0] dg_cnt_reg, dg_cnt_next;
  logic [6:0] loop_cnt_reg, loop_cnt_next;
  logic pin_lvl_reg, pin_lvl_next;
  logic det_reg, det_next;
  logic [7:0] gate_level_reg, gate_level_next;
  logic gate_en_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;

  // apb decode; one wait state so read data comes from a flop
  wire acc = psel & penable & ~pready_reg;
  wire done = psel & penable & pready_reg;
  wire wr = done & pwrite;
  wire sel_ctrl = paddr == `HSC_CTRL_OFS;
  wire sel_stat = paddr == `HSC_STAT_OFS;
  wire sel_fault = paddr == `HSC_FAULT_OFS;
  wire sel_oc = paddr == `HSC_OC_OFS;
  wire sel_ist = paddr == `HSC_IST_OFS;
  wire sel_saddr = paddr == `HSC_SADDR_OFS;
  wire sel_sdata = paddr == `HSC_SDATA_OFS;
  wire mapped = sel_ctrl | sel_stat | sel_fault | sel_oc | sel_ist |
    sel_saddr | sel_sdata;

  // mode and pin role
  wire fully_digital_mode = ctrl_reg[`HSC_CTRL_FDM];
  wire en_role = fully_digital_mode & ctrl_reg[`HSC_CTRL_DCM];
  wire run_cmd = ctrl_reg[`HSC_CTRL_ON];
  wire pin_hi = en_above_upper;
  wire pin_lo = en_below_lower;
  wire en_fall = en_role & pin_lvl_reg & pin_lo;
  wire det = ~en_role | det_reg;
  wire fault_any = |fault_reg;
  wire active = is_active(state_reg);

  // drain-source voltage and table index
  wire [11:0] vds = (vin_code > vout_code) ? vin_code - vout_code : 12'h000;
  wire [7:0] vds_round = 8'((13'(vds) + `HSC_VDS_HALF) >> 5);
  wire [6:0] vds_idx = (vds_round == 8'h00) ? 7'h00 :
    (vds_round > 8'(`HSC_SOA_N)) ? 7'(`HSC_SOA_N - 7'h01) :
    7'(vds_round - 8'h01);
  // exactly 95 degC stays on the cooler curve
  wire hot = ctrl_reg[`HSC_CTRL_TSNS] & (fet_temp > `HSC_TEMP_HOT);
  wire pulse = fully_digital_mode & ctrl_reg[`HSC_CTRL_PULSE];
  wire [1:0] bank = {hot, pulse};

  assign sif.look_addr = {bank, vds_idx};
  assign sif.cpu_addr = saddr_reg;
  assign sif.wr_en = wr & sel_sdata;
  assign sif.wr_addr = saddr_reg;
  assign sif.wr_data = pwdata[8:0];

  // current limit selection
  wire hsc_amp_t run_lim = amp_min(sif.look_data, oc_reg);
  wire hsc_amp_t cur_lim = (state_reg == HSC_ST_INIT) ?
    amp_min(run_lim, ist_reg) : run_lim;

  // enable deglitch
  wire [9:0] dg_target = 10'(ctrl_reg[`HSC_CTRL_DG_HI:`HSC_CTRL_DG_LO] *
    `HSC_DG_STEP_CYC);
  wire dg_done = dg_cnt_reg >= dg_target;
  wire start_ok = pin_hi & run_cmd & ~fault_any;
  wire kill = soc_trip | fault_any | ~run_cmd | (en_role & pin_lo);
  wire uv_drop = ~en_role & pin_lo;
  wire init_done = (vds < `HSC_VDS_ONE) & (vgs_code > `HSC_VGS_ON) &
    ~fault_any;
  wire over = isense_code > cur_lim;
  wire under = isense_code < cur_lim;
  wire gate_full = gate_level_reg == `HSC_GATE_MAX;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HSC_ST_STANDBY: begin
        if (start_ok) begin
          state_next = en_role ? HSC_ST_DEGLITCH : HSC_ST_INIT;
        end
      end
      HSC_ST_DEGLITCH: begin
        if (pin_lo || !run_cmd || fault_any) begin
          state_next = HSC_ST_STANDBY;
        end else if (dg_done) begin
          state_next = pin_hi ? HSC_ST_INIT : HSC_ST_STANDBY;
        end
      end
      HSC_ST_INIT, HSC_ST_ON, HSC_ST_IREG: begin
        if (kill) begin
          state_next = HSC_ST_STANDBY;
        end else if (uv_drop) begin
          state_next = HSC_ST_UVOFF;
        end else if (state_reg == HSC_ST_INIT && init_done) begin
          state_next = HSC_ST_ON;
        end else if (state_reg == HSC_ST_ON && over) begin
          state_next = HSC_ST_IREG;
        end else if (state_reg == HSC_ST_IREG && !over && gate_full) begin
          state_next = HSC_ST_ON;
        end
      end
      HSC_ST_UVOFF: state_next = HSC_ST_STANDBY;
      default: state_next = HSC_ST_STANDBY;
    endcase
  end

  wire act_next = is_active(state_next);
  assign dg_cnt_next = (state_reg == HSC_ST_DEGLITCH) ?
    dg_cnt_reg + 10'h001 : 10'h000;
  wire loop_tick = loop_cnt_reg == 7'(`HSC_LOOP_CYC - 1);
  assign loop_cnt_next = loop_tick ? 7'h00 : loop_cnt_reg + 7'h01;
  assign pin_lvl_next = pin_hi ? 1'b1 : pin_lo ? 1'b0 : pin_lvl_reg;
  assign det_next = en_fall ? 1'b0 :
    (en_role & pin_hi & ~pin_lvl_reg) ? 1'b1 : det_reg;

  // gate steps once per loop tick toward the active limit
  assign gate_level_next = !act_next ? 8'h00 :
    !loop_tick ? gate_level_reg :
    (over && gate_level_reg != 8'h00) ? gate_level_reg - 8'h01 :
    (under && !gate_full) ? gate_level_reg + 8'h01 :
    gate_level_reg;

  // faults: a new event wins over any clear in the same cycle
  wire [6:0] fault_set = {mem_err, fault_evt & {4{det}}, soc_trip,
    uv_drop & active};
  wire [6:0] w1c = (wr && sel_fault) ? pwdata[6:0] & `HSC_F_CLR : 7'h00;
  wire [6:0] clr = (en_fall ? `HSC_F_CLR : 7'h00) | w1c;
  assign fault_next = fault_set | (fault_reg & ~clr);

  wire [31:0] rdata_mux =
    sel_ctrl ? {21'h0, ctrl_reg} :
    sel_stat ? {7'h0, cur_lim, gate_level_reg, 2'h0, bank, pin_lvl_reg,
      state_reg} :
    sel_fault ? {25'h0, fault_reg} :
    sel_oc ? {23'h0, oc_reg} :
    sel_ist ? {23'h0, ist_reg} :
    sel_saddr ? {23'h0, saddr_reg} :
    sel_sdata ? {23'h0, sif.cpu_data} : 32'h0;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= acc;
      pslverr_reg <= acc & ~mapped;
      prdata_reg <= (acc && !pwrite) ? rdata_mux : 32'h0;
    end
  end

  // bus access stays live in every state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `HSC_CTRL_RST;
      oc_reg <= `HSC_OC_RST;
      ist_reg <= `HSC_IST_RST;
      saddr_reg <= `HSC_SADDR_RST;
    end else if (wr) begin
      if (sel_ctrl) ctrl_reg <= pwdata[10:0];
      if (sel_oc) oc_reg <= pwdata[8:0];
      if (sel_ist) ist_reg <= pwdata[8:0];
      if (sel_saddr) saddr_reg <= pwdata[8:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= HSC_ST_STANDBY;
      fault_reg <= 7'h00;
      dg_cnt_reg <= 10'h000;
      loop_cnt_reg <= 7'h00;
      pin_lvl_reg <= 1'b0;
      det_reg <= 1'b0;
      gate_level_reg <= 8'h00;
      gate_en_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fault_reg <= fault_next;
      dg_cnt_reg <= dg_cnt_next;
      loop_cnt_reg <= loop_cnt_next;
      pin_lvl_reg <= pin_lvl_next;
      det_reg <= det_next;
      gate_level_reg <= gate_level_next;
      gate_en_reg <= act_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign gate_en = gate_en_reg;
  assign gate_level = gate_level_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  dg_start_a: assert property (
    state_reg == HSC_ST_STANDBY && start_ok && en_role
    |=> state_reg == HSC_ST_DEGLITCH)
    else $error("deglitch timer did not start");

  dg_expire_a: assert property (
    state_reg == HSC_ST_DEGLITCH && dg_done && !pin_hi
    |=> state_reg == HSC_ST_STANDBY)
    else $error("started with enable pin not high");

  pin_off_a: assert property (
    en_role && pin_lo |=> !gate_en_reg && gate_level_reg == 8'h00)
    else $error("gate on with enable pin low");

  standby_hold_a: assert property (
    state_reg == HSC_ST_STANDBY && fault_set == 7'h00 && clr == 7'h00
    |=> $stable(fault_reg))
    else $error("fault bits changed in standby");

  uv_proc_a: assert property (
    uv_drop && active && !kill
    |=> state_reg == HSC_ST_UVOFF && fault_reg[`HSC_F_UV] && gate_en_reg
    ##1 state_reg == HSC_ST_STANDBY && !gate_en_reg)
    else $error("undervoltage procedure skipped");

  en_clear_a: assert property (
    en_fall && !mem_err
    |=> fault_reg[`HSC_F_MEM] == $past(fault_reg[`HSC_F_MEM]) &&
      (fault_reg[5:0] & ~$past(fault_set[5:0])) == 6'h00)
    else $error("enable fall clear wrong");

  curve_sel_a: assert property (
    (!fully_digital_mode |-> !sif.look_addr[7]) and
    (ctrl_reg[`HSC_CTRL_TSNS] && fet_temp > 8'h5f |-> sif.look_addr[8]))
    else $error("wrong area curve selected");

  init_lim_a: assert property (
    state_reg == HSC_ST_INIT |-> cur_lim <= ist_reg &&
      cur_lim <= oc_reg && cur_lim <= sif.look_data)
    else $error("startup limit not smallest");

  run_lim_a: assert property (
    state_reg == HSC_ST_ON || state_reg == HSC_ST_IREG
    |-> cur_lim == amp_min(sif.look_data, oc_reg))
    else $error("running limit wrong");

  init_exit_a: assert property (
    state_reg == HSC_ST_INIT ##1 state_reg == HSC_ST_ON
    |-> $past(vds < `HSC_VDS_ONE && vgs_code > `HSC_VGS_ON))
    else $error("left initial regulation early");

  idx_clamp_a: assert property (
    vds > 12'h0a10 |-> sif.look_addr[6:0] == 7'h4f)
    else $error("table index not clamped");

  soc_kill_a: assert property (
    soc_trip |=> !gate_en_reg ##1 !gate_en_reg || !soc_trip)
    else $error("severe trip did not cut gate");

  loop_step_a: assert property (
    act_next && active && loop_tick && over && gate_level_reg != 8'h00
    |=> gate_level_reg == $past(gate_level_reg) - 8'h01)
    else $error("gate not lowered over limit");
endmodule

/* hsc_fet_model.sv */
`timescale 1ns/10ps
module hsc_fet_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // gate drive and supply
  input wire logic gate_en,
  input wire logic [7:0] gate_level,
  input wire logic [11:0] vin_code,
  // sensed values
  output logic [11:0] vout_code,
  output logic [11:0] vgs_code,
  output logic [8:0] isense_code
);
  logic [3:0] div_reg;
  // a slow output charge keeps the drain voltage high early in start-up
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vout_code <= 12'h000;
      div_reg <= 4'h0;
    end else if (!gate_en) begin
      vout_code <= 12'h000;
    end else begin
      div_reg <= div_reg + 4'h1;
      if (div_reg == 4'hf && gate_level != 8'h00 && vout_code < vin_code)
        vout_code <= vout_code + 12'h001;
    end
  end
  assign vgs_code = gate_en ? {4'h0, gate_level} : 12'h000;
  assign isense_code = gate_en ? {1'b0, gate_level} : 9'h000;
endmodule

/* hsc_pkg.sv */
package hsc_pkg;
  typedef logic [8:0] hsc_amp_t;
  typedef enum logic [2:0] {
    HSC_ST_STANDBY = 3'b000,
    HSC_ST_DEGLITCH = 3'b001,
    HSC_ST_INIT = 3'b010,
    HSC_ST_ON = 3'b011,
    HSC_ST_IREG = 3'b100,
    HSC_ST_UVOFF = 3'b101
  } hsc_state_t;
endpackage

/* hsc_regs.svh */
`ifndef HSC_REGS_SVH
`define HSC_REGS_SVH
// timing
`define HSC_CLK_MHZ 125
`define HSC_DG_STEP_NS 1000
`define HSC_DG_STEP_CYC ((`HSC_DG_STEP_NS*`HSC_CLK_MHZ+999)/1000)
`define HSC_LOOP_NS 1000
`define HSC_LOOP_CYC ((`HSC_LOOP_NS*`HSC_CLK_MHZ)/1000)
// register byte offsets
`define HSC_CTRL_OFS 8'h00
`define HSC_STAT_OFS 8'h04
`define HSC_FAULT_OFS 8'h08
`define HSC_OC_OFS 8'h0c
`define HSC_IST_OFS 8'h10
`define HSC_SADDR_OFS 8'h14
`define HSC_SDATA_OFS 8'h18
// control fields
`define HSC_CTRL_ON 0
`define HSC_CTRL_FDM 1
`define HSC_CTRL_DCM 2
`define HSC_CTRL_PULSE 3
`define HSC_CTRL_TSNS 4
`define HSC_CTRL_DG_LO 8
`define HSC_CTRL_DG_HI 10
`define HSC_CTRL_RST 11'h007
// fault fields
`define HSC_F_UV 0
`define HSC_F_SOC 1
`define HSC_F_EXT_LO 2
`define HSC_F_EXT_HI 5
`define HSC_F_MEM 6
`define HSC_F_CLR 7'h3f
// limits, in 0.5 A steps, and the table address reset
`define HSC_OC_RST 9'h0c8
`define HSC_IST_RST 9'h1ff
`define HSC_SADDR_RST 9'h000
// measurement thresholds, volts in 1/32 V, temperature in degC; table sizes and gate maximum
`define HSC_VDS_HALF 13'h0010
`define HSC_VDS_ONE 12'h020
`define HSC_VGS_ON 12'h0f9
`define HSC_TEMP_HOT 8'h5f
`define HSC_SOA_N 7'h50
`define HSC_SOA_DEPTH 320
`define HSC_GATE_MAX 8'hff
`endif

/* hsc_soa_if.sv */
`timescale 1ns/10ps
interface hsc_soa_if;
  import hsc_pkg::*;
  // address is {curve bank[1:0], volt index[6:0]}
  logic wr_en;
  logic [8:0] wr_addr;
  hsc_amp_t wr_data;
  logic [8:0] look_addr;
  hsc_amp_t look_data;
  logic [8:0] cpu_addr;
  hsc_amp_t cpu_data;
  modport store (input wr_en, wr_addr, wr_data, look_addr, cpu_addr,
    output look_data, cpu_data);
  modport user (output wr_en, wr_addr, wr_data, look_addr, cpu_addr,
    input look_data, cpu_data);
endinterface

/* hsc_soa_table.sv */
`timescale 1ns/10ps
`include "hsc_regs.svh"
module hsc_soa_table import hsc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // table access
  hsc_soa_if.store sif
);
  // four curves of 80 entries, each entry a count of 0.5 A steps
  hsc_amp_t mem [0:`HSC_SOA_DEPTH-1];

  function automatic logic [8:0] lin(input logic [8:0] a);
    lin = {1'b0, a[8:7], 6'h00} + {3'h0, a[8:7], 4'h0} + {2'h0, a[6:0]};
  endfunction

  function automatic logic ok(input logic [8:0] a);
    ok = a[6:0] < `HSC_SOA_N;
  endfunction

  wire [8:0] wr_lin = lin(sif.wr_addr);
  wire [8:0] look_lin = lin(sif.look_addr);
  wire [8:0] cpu_lin = lin(sif.cpu_addr);

  // out-of-range indices read as zero amps and ignore writes
  assign sif.look_data = ok(sif.look_addr) ? mem[look_lin] : 9'h000;
  assign sif.cpu_data = ok(sif.cpu_addr) ? mem[cpu_lin] : 9'h000;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `HSC_SOA_DEPTH; i++) begin
        mem[i] <= 9'h000;
      end
    end else if (sif.wr_en && ok(sif.wr_addr)) begin
      mem[wr_lin] <= sif.wr_data;
    end
  end
endmodule

/* testbench.sv */
`timescale 1ns/10ps
`include "hsc_regs.svh"
module testbench;
  import hsc_pkg::*;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic en_above_upper, en_below_lower, soc_trip, mem_err, gate_en;
  logic [7:0] paddr, fet_temp, gate_level;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] vin_code, vout_code, vgs_code;
  logic [8:0] isense_code;
  logic [3:0] fault_evt;
  int err_total, n_checks;
  hsc_enable_limit u_hsc_enable_limit (.sys_clk(sys_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .en_above_upper(en_above_upper), .en_below_lower(en_below_lower),
    .vin_code(vin_code), .vout_code(vout_code), .vgs_code(vgs_code),
    .isense_code(isense_code), .fet_temp(fet_temp), .soc_trip(soc_trip),
    .fault_evt(fault_evt), .mem_err(mem_err), .gate_en(gate_en),
    .gate_level(gate_level));
  hsc_fet_model u_hsc_fet_model (.sys_clk(sys_clk), .resetn(resetn),
    .gate_en(gate_en), .gate_level(gate_level), .vin_code(vin_code),
    .vout_code(vout_code), .vgs_code(vgs_code), .isense_code(isense_code));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    chk("pready", 1, pready);
    if (pready !== 1'b1) close_out();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic wait_gate(input logic v, input int n);
    int i;
    i = 0;
    while (gate_en !== v && i < n) begin
      @(posedge sys_clk);
      i++;
    end
    chk("gate_en", v, gate_en);
  endtask
  task automatic pin(input logic hi);
    @(posedge sys_clk);
    en_above_upper <= hi;
    en_below_lower <= !hi;
  endtask
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, soc_trip, mem_err, en_above_upper} = 6'h00;
    en_below_lower = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    fault_evt = 4'h0;
    fet_temp = 8'h19;
    vin_code = 12'h600;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk("ctrl", `HSC_CTRL_OFS, 32'h007);
    rdchk("oc", `HSC_OC_OFS, 32'h0c8);
    rdchk("ist", `HSC_IST_OFS, 32'h1ff);
    rdchk("fault", `HSC_FAULT_OFS, 32'h0);
    rdchk("status", `HSC_STAT_OFS, 32'h0);
    rdchk("unmapped", 8'h1c, 32'h0);
    chk("pslverr", 1, er);
    // table bounds and 0.5 A quantum
    apb(1'b1, `HSC_SADDR_OFS, 32'h04f);
    apb(1'b1, `HSC_SDATA_OFS, 32'h3ff);
    rdchk("soa79", `HSC_SDATA_OFS, 32'h1ff);
    apb(1'b1, `HSC_SADDR_OFS, 32'h050);
    apb(1'b1, `HSC_SDATA_OFS, 32'h005);
    rdchk("soa80", `HSC_SDATA_OFS, 32'h0);
    // a drain voltage past the top of the table reads the last entry
    vin_code <= 12'hfff;
    apb(1'b0, `HSC_STAT_OFS, 32'h0);
    chk("limit", 32'h0c8, rd[24:16]);
    vin_code <= 12'h600;
    apb(1'b1, `HSC_SADDR_OFS, 32'h02f);
    apb(1'b1, `HSC_SDATA_OFS, 32'h050);
    // a short pulse shorter than the 1 us deglitch must not start
    apb(1'b1, `HSC_CTRL_OFS, 32'h107);
    pin(1'b1);
    repeat (30) @(posedge sys_clk);
    pin(1'b0);
    repeat (200) @(posedge sys_clk);
    chk("gate_en", 0, gate_en);
    pin(1'b1);
    repeat (60) @(posedge sys_clk);
    chk("gate_en", 0, gate_en);
    wait_gate(1'b1, 100);
    apb(1'b0, `HSC_STAT_OFS, 32'h0);
    chk("state", HSC_ST_INIT, rd[2:0]);
    chk("limit", 32'h050, rd[24:16]);
    apb(1'b1, `HSC_IST_OFS, 32'h020);
    apb(1'b0, `HSC_STAT_OFS, 32'h0);
    chk("limit", 32'h020, rd[24:16]);
    apb(1'b1, `HSC_OC_OFS, 32'h010);
    apb(1'b0, `HSC_STAT_OFS, 32'h0);
    chk("limit", 32'h010, rd[24:16]);
    pin(1'b0);
    wait_gate(1'b0, 2);
    chk("gate_level", 32'h0, gate_level);
    // standby still reports the table entry capped by the 0x10 limit
    rdchk("status", `HSC_STAT_OFS, 32'h00100000);
    // external fault kills the gate and stays until enable falls
    apb(1'b1, `HSC_CTRL_OFS, 32'h007);
    pin(1'b1);
    wait_gate(1'b1, 10);
    @(posedge sys_clk);
    fault_evt <= 4'h5;
    @(posedge sys_clk);
    fault_evt <= 4'h0;
    wait_gate(1'b0, 3);
    repeat (20) @(posedge sys_clk);
    rdchk("fault", `HSC_FAULT_OFS, 32'h014);
    pin(1'b0);
    repeat (2) @(posedge sys_clk);
    rdchk("fault", `HSC_FAULT_OFS, 32'h0);
    pin(1'b1);
    wait_gate(1'b1, 10);
    @(posedge sys_clk);
    soc_trip <= 1'b1;
    @(posedge sys_clk);
    soc_trip <= 1'b0;
    wait_gate(1'b0, 2);
    rdchk("fault", `HSC_FAULT_OFS, 32'h002);
    apb(1'b1, `HSC_FAULT_OFS, 32'h002);
    rdchk("fault", `HSC_FAULT_OFS, 32'h0);
    pin(1'b0);
    // on-bit cleared: a high enable alone must not start
    apb(1'b1, `HSC_CTRL_OFS, 32'h006);
    pin(1'b1);
    repeat (20) @(posedge sys_clk);
    chk("gate_en", 0, gate_en);
    pin(1'b0);
    // curve bank from temperature and mode
    apb(1'b1, `HSC_CTRL_OFS, 32'h01f);
    fet_temp <= 8'h60;
    apb(1'b0, `HSC_STAT_OFS, 32'h0);
    chk("bank", 32'h3, rd[5:4]);
    fet_temp <= `HSC_TEMP_HOT;
    apb(1'b0, `HSC_STAT_OFS, 32'h0);
    chk("bank", 32'h1, rd[5:4]);
    fet_temp <= 8'h60;
    apb(1'b1, `HSC_CTRL_OFS, 32'h019);
    apb(1'b0, `HSC_STAT_OFS, 32'h0);
    chk("bank", 32'h2, rd[5:4]);
    // undervoltage role: falling pin raises uv fault, not cleared by fall
    apb(1'b1, `HSC_CTRL_OFS, 32'h003);
    pin(1'b1);
    wait_gate(1'b1, 300);
    pin(1'b0);
    wait_gate(1'b0, 4);
    rdchk("fault", `HSC_FAULT_OFS, 32'h001);
    apb(1'b1, `HSC_FAULT_OFS, 32'h001);
    // memory fault survives both clearing paths
    @(posedge sys_clk);
    mem_err <= 1'b1;
    @(posedge sys_clk);
    mem_err <= 1'b0;
    rdchk("fault", `HSC_FAULT_OFS, 32'h040);
    apb(1'b1, `HSC_FAULT_OFS, 32'h07f);
    rdchk("fault", `HSC_FAULT_OFS, 32'h040);
    apb(1'b1, `HSC_CTRL_OFS, 32'h007);
    pin(1'b1);
    repeat (5) @(posedge sys_clk);
    chk("gate_en", 0, gate_en);
    pin(1'b0);
    repeat (2) @(posedge sys_clk);
    rdchk("fault", `HSC_FAULT_OFS, 32'h040);
    close_out();
  end
endmodule
